// ---- rtl/ocs_pkg.sv ----
// constants, register map and carrier types of the overcurrent/thermal sequencer
package ocs_pkg;

    // time base
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_WINDOW_NS = 75;
    localparam int SAMPLE_CYCLES = (SAMPLE_WINDOW_NS / CLK_PERIOD_NS) < 1 ?
        1 : SAMPLE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int HICCUP_TIME_MS = 20;
    localparam int HICCUP_CYCLES = HICCUP_TIME_MS * (CLK_HZ / 1000);
    localparam int HICCUP_W = 18;

    // switching cycle shaping
    localparam int SET_WIDTH_SHIFT = 3;
    localparam logic [7:0] PERIOD_MIN = 8'h08;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_HALF = 8'h80;
    localparam logic [7:0] DUTY_QUARTER = 8'h40;
    localparam logic [7:0] DUTY_EIGHTH = 8'h20;
    localparam logic [1:0] STAGE_LAST = 2'h3;
    localparam logic [1:0] OC_RUN_STEP = 2'h2;
    localparam logic [2:0] OK_RUN_STEP = 3'h3;
    localparam logic [6:0] OC_DEFAULT_CYCLES = 7'h08;
    localparam logic [9:0] OT_HYSTERESIS = 10'h019;

    // current limit codes for the three select-pin straps
    localparam logic [7:0] OC_LIMIT_FLOAT = 8'h40;
    localparam logic [7:0] OC_LIMIT_HIGH = 8'h60;
    localparam logic [7:0] OC_LIMIT_LOW = 8'h30;

    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_OC_FAULT_LIMIT = 4'h0;
    localparam logic [ADDR_W-1:0] REG_OC_WARN_LIMIT = 4'h1;
    localparam logic [ADDR_W-1:0] REG_OC_RESPONSE = 4'h2;
    localparam logic [ADDR_W-1:0] REG_OT_LIMIT = 4'h3;
    localparam logic [ADDR_W-1:0] REG_OT_RESPONSE = 4'h4;
    localparam logic [ADDR_W-1:0] REG_SWITCH_PERIOD = 4'h5;
    localparam logic [ADDR_W-1:0] REG_CLEAR_FAULTS = 4'h6;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;
    localparam logic [ADDR_W-1:0] REG_READ_CURRENT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_READ_TEMP = 4'h9;
    localparam logic [ADDR_W-1:0] REG_SEQ_STATE = 4'hA;

    // reset values
    localparam logic [7:0] RST_OC_FAULT_LIMIT = 8'h40;
    localparam logic [11:0] RST_OC_WARN_LIMIT = 12'h300;
    localparam logic [3:0] RST_OC_RESPONSE = 4'h0;
    localparam logic [9:0] RST_OT_LIMIT = 10'h091;
    localparam logic [7:0] RST_SWITCH_PERIOD = 8'h20;

    // status bit positions
    localparam int ST_OC_FAULT = 0;
    localparam int ST_OC_WARN = 1;
    localparam int ST_OT_FAULT = 2;
    localparam int ST_OC_LATCHED = 3;
    localparam int ST_OT_LATCHED = 4;
    localparam int ST_W = 5;

    // overcurrent response field: bit 0 latch, bits 3:1 count code
    localparam int OCR_LATCH = 0;

    typedef enum logic [1:0] {
        OT_IGNORE = 2'b00,
        OT_INHIBIT = 2'b01,
        OT_LATCH = 2'b10
    } ocs_ot_resp_type;

    typedef enum logic [1:0] {
        OP_RUN = 2'b00,
        OP_HICCUP = 2'b01,
        OP_LATCHED = 2'b10
    } ocs_op_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ocs_bus_req_type;

    typedef struct packed {
        logic [11:0] iout;
        logic ioutValid;
        logic [9:0] temp;
        logic tempValid;
    } ocs_telem_type;

    typedef struct packed {
        logic convEnable;
        logic setPulse;
        logic hsGate;
        logic lsGate;
    } ocs_gate_type;

endpackage

// ---- rtl/ocs_fault_sequencer.sv ----
// overcurrent and over-temperature fault sequencer with register port
module ocs_fault_sequencer
    import ocs_pkg::*;
#(
    parameter int HICCUP_COUNT = HICCUP_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire ocs_bus_req_type busReq,
    output logic [DATA_W-1:0] busRdData,
    input wire ocs_telem_type telem,
    input wire logic [7:0] dutyNominal,
    input wire logic ocCompPin,
    input wire logic limitSelPullUpPin,
    input wire logic limitSelPullDownPin,
    input wire logic analogModePin,
    output ocs_gate_type gates,
    output logic [7:0] ocThreshold,
    output logic faultAlert_n
);

    typedef struct packed {
        logic [1:0] ocSync;
        logic [1:0] selUpSync;
        logic [1:0] selDnSync;
        logic [1:0] modeSync;
        logic [7:0] ocFaultLimit;
        logic [11:0] ocWarnLimit;
        logic [3:0] ocResponse;
        logic [9:0] otLimit;
        ocs_ot_resp_type otResponse;
        logic [7:0] switchPeriod;
        logic [DATA_W-1:0] rdData;
        logic [7:0] phase;
        logic ocSeen;
        logic [6:0] ocTotal;
        logic [1:0] ocRun;
        logic [2:0] okRun;
        logic [1:0] stage;
        ocs_op_type op;
        logic [HICCUP_W-1:0] hiccupCnt;
        logic otActive;
        logic otLatched;
        logic [ST_W-1:0] status;
        logic [11:0] iout;
        logic [9:0] temp;
        ocs_gate_type gates;
        logic [7:0] threshold;
        logic alert_n;
    } ocs_state_type;

    localparam ocs_state_type RESET_STATE = '{
        ocSync: 2'h0,
        selUpSync: 2'h0,
        selDnSync: 2'h0,
        modeSync: 2'h0,
        ocFaultLimit: RST_OC_FAULT_LIMIT,
        ocWarnLimit: RST_OC_WARN_LIMIT,
        ocResponse: RST_OC_RESPONSE,
        otLimit: RST_OT_LIMIT,
        otResponse: OT_INHIBIT,
        switchPeriod: RST_SWITCH_PERIOD,
        rdData: 16'h0000,
        phase: 8'h00,
        ocSeen: 1'b0,
        ocTotal: 7'h00,
        ocRun: 2'h0,
        okRun: 3'h0,
        stage: 2'h0,
        op: OP_RUN,
        hiccupCnt: 18'h0_0000,
        otActive: 1'b0,
        otLatched: 1'b0,
        status: 5'h00,
        iout: 12'h000,
        temp: 10'h000,
        gates: 4'h0,
        threshold: RST_OC_FAULT_LIMIT,
        alert_n: 1'b1
    };

    localparam logic [HICCUP_W-1:0] HICCUP_LAST =
        HICCUP_W'(HICCUP_COUNT - 1);
    localparam logic [7:0] SAMPLE_LEN = 8'(SAMPLE_CYCLES);
    ocs_state_type s;
    ocs_state_type next_s;

    // duty ceiling for each foldback stage
    function automatic logic [7:0] dutyCap(input logic [1:0] stage);
        logic [7:0] cap;
        case (stage)
            2'h0: cap = DUTY_FULL;
            2'h1: cap = DUTY_HALF;
            2'h2: cap = DUTY_QUARTER;
            2'h3: cap = DUTY_EIGHTH;
            default: cap = DUTY_FULL;
        endcase
        return cap;
    endfunction

    // limited-cycle budget from the response count code
    function automatic logic [6:0] limitCycles(input logic [2:0] code);
        logic [3:0] steps;
        steps = {1'b0, code} + 4'h1;
        return {steps, 3'b000};
    endfunction

    // three-way strap: floating reads high under pull-up, low under pull-down
    function automatic logic [7:0] strapLimit(input logic up,
                                              input logic dn);
        logic [7:0] lim;
        case ({up, dn})
            2'b10: lim = OC_LIMIT_FLOAT;
            2'b11: lim = OC_LIMIT_HIGH;
            2'b00: lim = OC_LIMIT_LOW;
            default: lim = OC_LIMIT_FLOAT;
        endcase
        return lim;
    endfunction

    always_comb begin
        logic analogMode;
        logic clearFaults;
        logic running;
        logic cycleEnd;
        logic lowDuty;
        logic latchOnLimit;
        logic [6:0] ocBudget;
        logic [6:0] totalNext;
        logic [7:0] effDuty;
        logic [7:0] setWidth;
        logic [15:0] onProduct;
        logic [7:0] onLen;
        logic [8:0] onEnd;
        logic tempOver;
        logic tempBack;
        logic [9:0] otRestart;
        logic hsOn;

        next_s = s;
        analogMode = 1'b0;
        clearFaults = 1'b0;
        running = 1'b0;
        cycleEnd = 1'b0;
        lowDuty = 1'b0;
        latchOnLimit = 1'b0;
        ocBudget = OC_DEFAULT_CYCLES;
        totalNext = 7'h00;
        effDuty = 8'h00;
        setWidth = 8'h00;
        onProduct = 16'h0000;
        onLen = 8'h00;
        onEnd = 9'h000;
        tempOver = 1'b0;
        tempBack = 1'b0;
        otRestart = 10'h000;
        hsOn = 1'b0;

        // pins cross in through two flops before anything looks at them
        next_s.ocSync = {s.ocSync[0], ocCompPin};
        next_s.selUpSync = {s.selUpSync[0], limitSelPullUpPin};
        next_s.selDnSync = {s.selDnSync[0], limitSelPullDownPin};
        next_s.modeSync = {s.modeSync[0], analogModePin};
        analogMode = s.modeSync[1];

        // register writes
        if (busReq.wr) begin
            case (busReq.addr)
                REG_OC_FAULT_LIMIT: next_s.ocFaultLimit = busReq.wdata[7:0];
                REG_OC_WARN_LIMIT: next_s.ocWarnLimit = busReq.wdata[11:0];
                REG_OC_RESPONSE: next_s.ocResponse = busReq.wdata[3:0];
                REG_OT_LIMIT: next_s.otLimit = busReq.wdata[9:0];
                REG_OT_RESPONSE: begin
                    // the unused fourth code falls back to inhibit
                    next_s.otResponse = (busReq.wdata[1:0] == 2'h3) ?
                        OT_INHIBIT : ocs_ot_resp_type'(busReq.wdata[1:0]);
                end
                REG_SWITCH_PERIOD: begin
                    // below eight clocks the set pulse would vanish
                    next_s.switchPeriod = (busReq.wdata[7:0] < PERIOD_MIN) ?
                        PERIOD_MIN : busReq.wdata[7:0];
                end
                REG_CLEAR_FAULTS: clearFaults = 1'b1;
                default: ;
            endcase
        end

        // read data stands one cycle after the strobe only
        next_s.rdData = 16'h0000;
        if (busReq.rd) begin
            case (busReq.addr)
                REG_OC_FAULT_LIMIT: next_s.rdData = {8'h00, s.ocFaultLimit};
                REG_OC_WARN_LIMIT: next_s.rdData = {4'h0, s.ocWarnLimit};
                REG_OC_RESPONSE: next_s.rdData = {12'h000, s.ocResponse};
                REG_OT_LIMIT: next_s.rdData = {6'h00, s.otLimit};
                REG_OT_RESPONSE: next_s.rdData = {14'h0000, s.otResponse};
                REG_SWITCH_PERIOD: next_s.rdData = {8'h00, s.switchPeriod};
                REG_STATUS: next_s.rdData = {11'h000, s.status};
                REG_READ_CURRENT: next_s.rdData = {4'h0, s.iout};
                REG_READ_TEMP: begin
                    next_s.rdData = {{6{s.temp[9]}}, s.temp};
                end
                REG_SEQ_STATE: begin
                    next_s.rdData = {1'b0, s.ocTotal, s.stage,
                                     s.otLatched, s.otActive, 2'h0, s.op};
                end
                default: next_s.rdData = 16'h0000;
            endcase
        end

        // sticky status: a clear in the same cycle as a new event loses
        if (clearFaults) begin
            next_s.status = '0;
            next_s.otLatched = 1'b0;
        end

        // telemetry
        if (telem.ioutValid) begin
            next_s.iout = telem.iout;
            if (telem.iout > s.ocWarnLimit) begin
                next_s.status[ST_OC_WARN] = 1'b1;
            end
        end
        if (telem.tempValid) begin
            next_s.temp = telem.temp;
        end

        // comparator reference: strap in analog mode, register otherwise
        if (analogMode) begin
            next_s.threshold = strapLimit(s.selUpSync[1],
                                          s.selDnSync[1]);
        end else begin
            next_s.threshold = s.ocFaultLimit;
        end

        // over-temperature with hysteresis
        otRestart = s.otLimit - OT_HYSTERESIS;
        tempOver = $signed(s.temp) > $signed(s.otLimit);
        tempBack = $signed(s.temp) <= $signed(otRestart);
        next_s.status[ST_OT_FAULT] = next_s.status[ST_OT_FAULT] | tempOver;
        case (s.otResponse)
            OT_IGNORE: next_s.otActive = 1'b0;
            OT_INHIBIT: begin
                if (tempOver) begin
                    next_s.otActive = 1'b1;
                end else if (tempBack) begin
                    next_s.otActive = 1'b0;
                end
            end
            OT_LATCH: begin
                next_s.otActive = 1'b0;
                if (tempOver) begin
                    next_s.otLatched = 1'b1;
                    next_s.status[ST_OT_LATCHED] = 1'b1;
                end
            end
            default: next_s.otActive = 1'b0;
        endcase

        // phase parks at 0 while off, so a restart opens on a set pulse
        running = (s.op == OP_RUN) && !s.otActive && !s.otLatched;
        cycleEnd = s.phase >= s.switchPeriod - 8'h01;
        next_s.phase = (cycleEnd || !running) ? 8'h00 : s.phase + 8'h01;
        setWidth = s.switchPeriod >> SET_WIDTH_SHIFT;
        lowDuty = dutyNominal < DUTY_EIGHTH;
        effDuty = (dutyNominal < dutyCap(s.stage)) ?
            dutyNominal : dutyCap(s.stage);
        onProduct = s.switchPeriod * effDuty;
        onLen = onProduct[15:8];
        onEnd = {1'b0, setWidth} + {1'b0, onLen};
        // high side opens only at set fall, never on a mid-cycle duty rise
        hsOn = (s.phase == setWidth || (s.gates.hsGate && s.phase > setWidth))
               && ({1'b0, s.phase} < onEnd);
        // valley sample right after the set pulse rises
        if (running && s.phase < SAMPLE_LEN && s.ocSync[1]) begin
            next_s.ocSeen = 1'b1;
        end
        // limited-cycle budget and final action
        if (analogMode) begin
            ocBudget = OC_DEFAULT_CYCLES;
        end else begin
            ocBudget = limitCycles(s.ocResponse[3:1]);
            latchOnLimit = s.ocResponse[OCR_LATCH];
        end

        case (s.op)
            OP_RUN: begin
                if (running && cycleEnd) begin
                    next_s.ocSeen = 1'b0;
                    if (s.ocSeen) begin
                        next_s.status[ST_OC_FAULT] = 1'b1;
                        totalNext = s.ocTotal + 7'h01;
                        next_s.ocTotal = totalNext;
                        next_s.okRun = 3'h0;
                        if (s.ocRun == OC_RUN_STEP) begin
                            next_s.ocRun = 2'h0;
                            if (s.stage != STAGE_LAST && !lowDuty) begin
                                next_s.stage = s.stage + 2'h1;
                            end
                        end else begin
                            next_s.ocRun = s.ocRun + 2'h1;
                        end
                        if (totalNext >= ocBudget) begin
                            if (latchOnLimit) begin
                                next_s.op = OP_LATCHED;
                                next_s.status[ST_OC_LATCHED] = 1'b1;
                            end else begin
                                next_s.op = OP_HICCUP;
                                next_s.hiccupCnt = '0;
                            end
                        end
                    end else begin
                        next_s.ocRun = 2'h0;
                        if (s.stage != 2'h0) begin
                            if (s.okRun == OK_RUN_STEP) begin
                                next_s.okRun = 3'h0;
                                next_s.stage = s.stage - 2'h1;
                            end else begin
                                next_s.okRun = s.okRun + 3'h1;
                            end
                        end else begin
                            // a clean cycle at full duty ends the episode
                            next_s.okRun = 3'h0;
                            next_s.ocTotal = 7'h00;
                        end
                    end
                end
            end
            OP_HICCUP: begin
                // off period timed on mclk, the internal reference
                next_s.hiccupCnt = s.hiccupCnt + 1'b1;
                next_s.ocSeen = 1'b0;
                if (s.hiccupCnt >= HICCUP_LAST) begin
                    next_s.op = OP_RUN;
                    next_s.hiccupCnt = '0;
                    next_s.ocTotal = 7'h00;
                    next_s.ocRun = 2'h0;
                    next_s.okRun = 3'h0;
                    next_s.stage = 2'h0;
                end
            end
            OP_LATCHED: begin
                next_s.ocSeen = 1'b0;
                if (clearFaults) begin
                    next_s.op = OP_RUN;
                    next_s.ocTotal = 7'h00;
                    next_s.ocRun = 2'h0;
                    next_s.okRun = 3'h0;
                    next_s.stage = 2'h0;
                end
            end
            default: next_s.op = OP_RUN;
        endcase

        // gate drive: both switches off whenever conversion is disabled
        next_s.gates.convEnable = running;
        next_s.gates.setPulse = running && (s.phase < setWidth);
        next_s.gates.hsGate = running && hsOn;
        next_s.gates.lsGate = running && !hsOn;

        next_s.alert_n = ~(|next_s.status);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign busRdData = s.rdData;
    assign gates = s.gates;
    assign ocThreshold = s.threshold;
    assign faultAlert_n = s.alert_n;

endmodule // ocs_fault_sequencer

// ---- tb/ocs_host_model.sv ----
// host model on the register port of the sequencer
module ocs_host_model
    import ocs_pkg::*;
(
    input wire logic mclk,
    input wire logic [DATA_W-1:0] busRdData,
    output ocs_bus_req_type busReq
);
    timeunit 1ns;
    timeprecision 1ns;
    initial busReq = '0;
    // strobe launched at one edge, dropped at the next
    task automatic write(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        busReq <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        busReq <= '0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic read(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        busReq <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge mclk);
        busReq <= '0;
        @(negedge mclk);
        d = busRdData;
    endtask
    task automatic clearFaults();
        write(REG_CLEAR_FAULTS, 16'h0001);
    endtask
    task automatic keepOcLimit();
        write(REG_OC_FAULT_LIMIT, 16'h0040);
    endtask
endmodule // ocs_host_model

// ---- tb/ocs_checker.sv ----
// port assertions for the fault sequencer
module ocs_checker
    import ocs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire ocs_bus_req_type busReq,
    input wire logic [DATA_W-1:0] busRdData,
    input wire ocs_telem_type telem,
    input wire logic [7:0] dutyNominal,
    input wire logic ocCompPin,
    input wire logic limitSelPullUpPin,
    input wire logic limitSelPullDownPin,
    input wire logic analogModePin,
    input wire ocs_gate_type gates,
    input wire logic [7:0] ocThreshold,
    input wire logic faultAlert_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_rd_idle: assert property (!$past(busReq.rd) |-> !busRdData)
        else $error("read data outside slot");
    chk_thr_float: assert property (
        (analogModePin && limitSelPullUpPin && !limitSelPullDownPin) [*4]
        |=> ocThreshold == OC_LIMIT_FLOAT) else $error("bad strap limit");
    chk_hs_in_set: assert property (
        gates.setPulse |-> !gates.hsGate) else $error("hs in set pulse");
    chk_hs_start: assert property (
        $rose(gates.hsGate) |-> $fell(gates.setPulse))
        else $error("hs not at set fall");
    chk_set_width: assert property (
        $fell(gates.setPulse) && gates.convEnable
        |-> $past(gates.setPulse, 4) && !$past(gates.setPulse, 5))
        else $error("set pulse width");
    chk_off_quiet: assert property (
        !gates.convEnable |-> !gates.hsGate && !gates.lsGate)
        else $error("switch on while off");
    chk_ls_fill: assert property (
        gates.convEnable |-> gates.lsGate != gates.hsGate)
        else $error("gates not complementary");
    chk_off_hold: assert property (
        $fell(gates.convEnable) |=> !gates.convEnable [*8])
        else $error("short off period");
endmodule // ocs_checker
bind ocs_fault_sequencer ocs_checker chk (.mclk(mclk), .rst_n(rst_n),
    .busReq(busReq), .busRdData(busRdData), .telem(telem),
    .dutyNominal(dutyNominal), .ocCompPin(ocCompPin),
    .limitSelPullUpPin(limitSelPullUpPin),
    .limitSelPullDownPin(limitSelPullDownPin),
    .analogModePin(analogModePin), .gates(gates),
    .ocThreshold(ocThreshold), .faultAlert_n(faultAlert_n));

// ---- tb/ocs_fault_sequencer_tb.sv ----
// self-checking bench for the fault sequencer
module ocs_fault_sequencer_tb
    import ocs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HICC = 50;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    ocs_bus_req_type busReq;
    logic [DATA_W-1:0] busRdData;
    ocs_telem_type telem = '0;
    logic [7:0] dutyNominal = 8'hC0;
    logic ocCompPin = 1'b0;
    logic selUp = 1'b1;
    logic selDn = 1'b0;
    logic analogModePin = 1'b0;
    ocs_gate_type gates;
    logic [7:0] ocThreshold;
    logic faultAlert_n;
    int error_cnt = 0;
    int n_checks = 0;
    int seed = 32403;
    int hsRun = 0;
    logic [7:0] lastW = '0;
    logic [31:0] seen = '0;
    logic [15:0] rv;
    logic [31:0] v;
    always #50 mclk = ~mclk;
    ocs_fault_sequencer #(.HICCUP_COUNT(HICC)) uut (.mclk(mclk),
        .rst_n(rst_n), .busReq(busReq), .busRdData(busRdData),
        .telem(telem), .dutyNominal(dutyNominal), .ocCompPin(ocCompPin),
        .limitSelPullUpPin(selUp), .limitSelPullDownPin(selDn),
        .analogModePin(analogModePin), .gates(gates),
        .ocThreshold(ocThreshold), .faultAlert_n(faultAlert_n));
    ocs_host_model host (.mclk(mclk), .busRdData(busRdData),
        .busReq(busReq));
    // high-side widths seen, one bit per width
    always @(posedge mclk) begin
        if (gates.hsGate === 1'b1) begin
            hsRun <= hsRun + 1;
        end else if (hsRun > 0) begin
            seen[hsRun[4:0]] <= 1'b1;
            lastW <= 8'(hsRun);
            hsRun <= 0;
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // enable must reach v after lo..hi-1 cycles
    task automatic waitConv(input logic v, input int lo, input int hi);
        int n = 0;
        while (gates.convEnable !== v && n < hi) begin
            @(negedge mclk);
            n++;
        end
        n_checks++;
        if (n < lo || n >= hi) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t enable after %0d", $time, n);
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
        host.read(a, rv);
        cmp(rv, e);
    endtask
    task automatic comp(input logic c, input int cyc);
        @(posedge mclk);
        ocCompPin <= c;
        seen <= '0;
        repeat (cyc) @(negedge mclk);
    endtask
    task automatic setTemp(input logic [9:0] t);
        @(posedge mclk);
        telem.temp <= t;
        telem.tempValid <= 1'b1;
        @(posedge mclk);
        telem.tempValid <= 1'b0;
    endtask
    function automatic logic [15:0] expStatus(input logic [11:0] c);
        return {14'h0000, c > RST_OC_WARN_LIMIT, 1'b0};
    endfunction
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        host.clearFaults();
        host.keepOcLimit();
        rdchk(REG_OC_WARN_LIMIT, 16'h0300);
        rdchk(REG_OT_LIMIT, 16'h0091);
        rdchk(REG_OT_RESPONSE, 16'h0001);
        rdchk(4'hB, 16'h0000);
        // warn limit boundary first, then random currents
        for (int i = 0; i < 6; i++) begin
            host.clearFaults();
            v = $random(seed);
            @(posedge mclk);
            telem.iout <= i == 0 ? 12'h301 : i == 1 ? 12'h300 : v[11:0];
            telem.temp <= {3'b000, v[18:12]};
            telem.ioutValid <= 1'b1;
            telem.tempValid <= 1'b1;
            @(posedge mclk);
            telem.ioutValid <= 1'b0;
            telem.tempValid <= 1'b0;
            rdchk(REG_READ_CURRENT, {4'h0, telem.iout});
            rdchk(REG_READ_TEMP, {6'h00, telem.temp});
            rdchk(REG_STATUS, expStatus(telem.iout));
            cmp({15'h0000, faultAlert_n},
                16'h0001 ^ expStatus(telem.iout) >> 1);
            cmp({15'h0000, gates.convEnable}, 16'h0001);
        end
        host.clearFaults();
        host.write(REG_OC_RESPONSE, 16'h000E);
        comp(1'b1, 384);
        cmp({13'h0000, seen[16], seen[8], seen[4]}, 16'h0007);
        cmp({15'h0000, gates.convEnable}, 16'h0001);
        comp(1'b0, 640);
        cmp({seen[16], seen[8], 6'h00, lastW}, 16'hC018);
        dutyNominal <= 8'h18;
        // let a pulse cut short by the duty change be logged before reset
        repeat (64) @(negedge mclk);
        comp(1'b1, 384);
        cmp(seen[31:16] | seen[15:0], 16'h0008);
        comp(1'b0, 512);
        dutyNominal <= 8'hC0;
        host.write(REG_OC_RESPONSE, 16'h0003);
        comp(1'b1, 0);
        waitConv(1'b0, 480, 584);
        repeat (3 * HICC) @(negedge mclk);
        cmp({15'h0000, gates.convEnable}, 16'h0000);
        comp(1'b0, 0);
        host.clearFaults();
        waitConv(1'b1, 0, 8);
        analogModePin <= 1'b1;
        comp(1'b1, 8);
        waitConv(1'b0, 224, 296);
        waitConv(1'b1, HICC - 1, HICC + 2);
        waitConv(1'b0, 224, 296);
        comp(1'b0, 0);
        waitConv(1'b1, HICC - 1, HICC + 2);
        repeat (640) @(negedge mclk);
        cmp({15'h0000, gates.convEnable}, 16'h0001);
        for (int s = 0; s < 3; s++) begin
            @(posedge mclk);
            selUp <= s < 2;
            selDn <= s == 1;
            repeat (6) @(negedge mclk);
            cmp({8'h00, ocThreshold}, s == 0 ? OC_LIMIT_FLOAT :
                s == 1 ? OC_LIMIT_HIGH : OC_LIMIT_LOW);
        end
        analogModePin <= 1'b0;
        setTemp(10'h050);
        host.write(REG_OT_LIMIT, 16'h0064);
        setTemp(10'h065);
        waitConv(1'b0, 0, 6);
        setTemp(10'h04C);
        repeat (10) @(negedge mclk);
        cmp({15'h0000, gates.convEnable}, 16'h0000);
        setTemp(10'h04B);
        waitConv(1'b1, 0, 6);
        host.write(REG_OT_RESPONSE, 16'h0000);
        setTemp(10'h0C8);
        repeat (10) @(negedge mclk);
        cmp({15'h0000, gates.convEnable}, 16'h0001);
        host.write(REG_OT_RESPONSE, 16'h0002);
        setTemp(10'h0C8);
        waitConv(1'b0, 0, 6);
        setTemp(10'h014);
        repeat (10) @(negedge mclk);
        cmp({15'h0000, gates.convEnable}, 16'h0000);
        host.clearFaults();
        waitConv(1'b1, 0, 6);
        conclude();
    end
endmodule // ocs_fault_sequencer_tb
